// [core/teq_defs.vh]
/*
 constants for the touch event qualifier: register offsets, field positions,
 reset values and timing counts. assumes a 100 MHz system clock.
*/
`ifndef TEQ_DEFS_VH
`define TEQ_DEFS_VH

// register offsets
`define TEQ_ADDR_RECAL 8'h26
`define TEQ_ADDR_IRQ_EN 8'h27
`define TEQ_ADDR_RPT_EN 8'h28
`define TEQ_ADDR_MT_CFG 8'h2a
`define TEQ_ADDR_PAT_CFG 8'h2b
`define TEQ_ADDR_PAT_SEL 8'h2d
`define TEQ_ADDR_TIMING 8'h23
`define TEQ_ADDR_RPT_CFG 8'h22
`define TEQ_ADDR_STATUS 8'h00
`define TEQ_ADDR_TOUCH 8'h03

// reset values
`define TEQ_RST_IRQ_EN 6'h3f
`define TEQ_RST_RPT_EN 6'h3f
`define TEQ_RST_MT_CFG 8'h80
`define TEQ_RST_PAT_CFG 8'h00
`define TEQ_RST_PAT_SEL 6'h3f
`define TEQ_RST_MPRESS 4'h7
`define TEQ_RST_RPT 4'h4

// field positions
`define TEQ_MT_BLK_BIT 7
`define TEQ_MT_LIM_HI 3
`define TEQ_MT_LIM_LO 2
`define TEQ_PAT_EN_BIT 7
`define TEQ_PAT_TH_HI 3
`define TEQ_PAT_TH_LO 2
`define TEQ_PAT_CMP_BIT 1
`define TEQ_PAT_ALERT_BIT 0
`define TEQ_ST_IRQ_BIT 0
`define TEQ_ST_TOO_MANY_TOUCHES_FLAG_BIT 2
`define TEQ_ST_PAT_BIT 1

// timing: one step of press and repeat times
`define TEQ_STEP_MS 35
`define TEQ_CLK_KHZ 100000
`define TEQ_STEP_CYC (`TEQ_STEP_MS * `TEQ_CLK_KHZ)

`endif

// [core/teq_step_timer.v]
/*
 step timer: one-cycle tick every STEP_CYC clocks while run is high.
 assumes synchronous active-low reset on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module teq_step_timer #(
   parameter STEP_CYC = 3500000
) (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // control
   input wire run,
   output reg tick
);
   reg [31:0] cnt;
   always @(posedge clk_sys) begin
      if (!nrst || !run) begin
         cnt <= 32'h0;
         tick <= 1'b0;
      end else if (cnt == STEP_CYC - 1) begin
         cnt <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [core/teq_input_qual.v]
/*
 one sensor input: classifies touch against press-and-hold and emits
 interrupt events. assumes a shared 35 ms step tick and that blocked
 inputs present no touch.
*/
`timescale 1ns/100ps
`default_nettype none
module teq_input_qual (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // per input
   input wire touch,
   input wire autorepeat_enable,
   input wire release_irq_select,
   input wire step_tick,
   input wire [3:0] min_press,
   input wire [3:0] repeat_interval,
   // events
   output reg irq_event
);
   reg touch_q;
   reg held;
   reg [4:0] steps;
   always @(posedge clk_sys) begin
      if (!nrst) begin
         touch_q <= 1'b0;
         held <= 1'b0;
         steps <= 5'h0;
         irq_event <= 1'b0;
      end else begin
         touch_q <= touch;
         irq_event <= 1'b0;
         if (touch && !touch_q) begin
            irq_event <= 1'b1;
            held <= 1'b0;
            steps <= 5'h0;
         end else if (!touch && touch_q) begin
            // plain touch may interrupt at release; a hold does not
            if (!autorepeat_enable)
               irq_event <= 1'b1;
            else if (!held)
               irq_event <= release_irq_select;
         end else if (touch && autorepeat_enable && step_tick) begin
            if (!held) begin
               if (steps == {1'b0, min_press} + 5'h1) begin
                  held <= 1'b1;
                  irq_event <= 1'b1;
                  steps <= 5'h0;
               end else begin
                  steps <= steps + 5'h1;
               end
            end else if (steps == {1'b0, repeat_interval}) begin
               irq_event <= 1'b1;
               steps <= 5'h0;
            end else begin
               steps <= steps + 5'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [core/teq_top.v]
/*
 touch event qualifier: recalibration requests, interrupt enables,
 auto-repeat, multiple-touch blocking and touch pattern detection.
 assumes a register port already decoded from the serial bus, and raw
 touch, over-pattern-threshold and noise flags from the analog front end.
*/
// Summary of operation
// - recal bit set starts recal, self clears
// - touch interrupts only with input enable set
// - no repeat: interrupt at touch and release
// - repeat plain touch: release per release select
// - hold: interrupt repeatedly at repeat interval
// - blocking on by default, limit touches flagged
// - blocking off blocks nothing
// - reselect in order input one to six
// - limit field codes to one..four touches
// - excess touches blocked, multi flag set
// - pattern detector only when enabled, reset off
// - pattern threshold fraction code to front end
// - pattern mode: all selected inputs over
// - count mode: over count at least popcount
// - pattern event blocks touches and interrupts
// - pattern block lasts while condition holds
// - pattern flag clears only on interrupt clear
// - alert pin only with alert enable
// - pattern select register, default all inputs
// - hold beyond minimum press is press-and-hold
// - repeat interval in 35 ms steps
`timescale 1ns/100ps
`default_nettype none
`include "teq_defs.vh"
module teq_top #(
   parameter STEP_CYC = `TEQ_STEP_CYC
) (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // front end
   input wire [5:0] raw_touch,
   input wire [5:0] over_pattern_th,
   input wire [5:0] noise_flag,
   input wire [5:0] recal_done,
   input wire release_irq_select,
   // to front end
   output reg [5:0] recal_start,
   output reg [1:0] pattern_threshold_fraction,
   // pins
   output reg irq_n,
   output reg alert_n
);
   localparam ST_IDLE = 2'b01;
   localparam ST_BLOCK = 2'b10;
   localparam [7:0] RST_MT_CFG = `TEQ_RST_MT_CFG;

   reg [5:0] recal_request;
   reg [5:0] irq_enable;
   reg [5:0] autorepeat_enable;
   reg touch_blocking_enable;
   reg [1:0] simultaneous_touch_limit;
   reg [7:0] pattern_cfg;
   reg [5:0] pattern_select;
   reg [3:0] min_press;
   reg [3:0] repeat_interval;
   reg [5:0] touch_status;
   reg [5:0] allowed;
   reg too_many_touches_flag;
   reg pattern_event_flag;
   reg irq_flag;
   reg alert_flag;
   reg [1:0] pat_state;
   reg [5:0] next_allowed;
   reg [2:0] n_sel;
   reg [2:0] n_over;
   reg [2:0] limit;
   reg pat_cond;
   reg excess;
   integer i;

   wire [5:0] over_or_noise = over_pattern_th | noise_flag;
   wire pattern_detect_enable = pattern_cfg[`TEQ_PAT_EN_BIT];
   wire pattern_compare_mode = pattern_cfg[`TEQ_PAT_CMP_BIT];
   wire pattern_alert_enable = pattern_cfg[`TEQ_PAT_ALERT_BIT];
   wire pat_block = (pat_state == ST_BLOCK);
   wire [5:0] qual_touch = raw_touch & allowed & {6{~pat_block}};
   wire [5:0] events;
   wire step_tick;
   wire any_touch = |raw_touch;

   // touch selection and pattern condition
   always @* begin
      limit = {1'b0, simultaneous_touch_limit} + 3'h1;
      n_sel = 3'h0;
      n_over = 3'h0;
      excess = 1'b0;
      next_allowed = 6'h0;
      for (i = 0; i < 6; i = i + 1) begin
         n_sel = n_sel + {2'b00, pattern_select[i]};
         n_over = n_over + {2'b00, over_or_noise[i]};
      end
      if (!touch_blocking_enable) begin
         next_allowed = 6'h3f;
      end else begin
         // keep flagged pads still held, fill free slots in input order, lowest first
         next_allowed = allowed & raw_touch;
         for (i = 0; i < 6; i = i + 1) begin
            if (raw_touch[i] && !next_allowed[i]) begin
               if (n_cnt(next_allowed) < limit)
                  next_allowed[i] = 1'b1;
               else
                  excess = 1'b1;
            end
         end
      end
      if (pattern_compare_mode)
         pat_cond = ((over_or_noise & pattern_select) == pattern_select);
      else
         pat_cond = (n_over >= n_sel);
      pat_cond = pat_cond & pattern_detect_enable;
   end

   function [2:0] n_cnt;
      input [5:0] v;
      integer k;
      begin
         n_cnt = 3'h0;
         for (k = 0; k < 6; k = k + 1)
            n_cnt = n_cnt + {2'b00, v[k]};
      end
   endfunction

   teq_step_timer #(
      .STEP_CYC(STEP_CYC)
   ) u_timer (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .run(any_touch),
      .tick(step_tick)
   );

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_in
         teq_input_qual u_q (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .touch(qual_touch[g]),
            .autorepeat_enable(autorepeat_enable[g]),
            .release_irq_select(release_irq_select),
            .step_tick(step_tick),
            .min_press(min_press),
            .repeat_interval(repeat_interval),
            .irq_event(events[g])
         );
      end
   endgenerate

   wire st_clear = reg_wr && (reg_addr == `TEQ_ADDR_STATUS) && !reg_wdata[`TEQ_ST_IRQ_BIT];
   wire pat_rise = pat_cond && (pat_state == ST_IDLE);
   // a pattern block looks like a release to the qualifiers; keep it quiet
   wire touch_irq = |(events & irq_enable & {6{~pat_block}});

   always @(posedge clk_sys) begin
      if (!nrst) begin
         recal_request <= 6'h0;
         recal_start <= 6'h0;
         irq_enable <= `TEQ_RST_IRQ_EN;
         autorepeat_enable <= `TEQ_RST_RPT_EN;
         touch_blocking_enable <= RST_MT_CFG[`TEQ_MT_BLK_BIT];
         simultaneous_touch_limit <= 2'h0;
         pattern_cfg <= `TEQ_RST_PAT_CFG;
         pattern_select <= `TEQ_RST_PAT_SEL;
         min_press <= `TEQ_RST_MPRESS;
         repeat_interval <= `TEQ_RST_RPT;
         pattern_threshold_fraction <= 2'h0;
         allowed <= 6'h0;
         touch_status <= 6'h0;
         too_many_touches_flag <= 1'b0;
         pattern_event_flag <= 1'b0;
         irq_flag <= 1'b0;
         alert_flag <= 1'b0;
         pat_state <= ST_IDLE;
         irq_n <= 1'b1;
         alert_n <= 1'b1;
         reg_rdata <= 8'h00;
      end else begin
         recal_start <= 6'h0;
         allowed <= next_allowed;
         if (reg_wr) begin
            case (reg_addr)
               `TEQ_ADDR_RECAL: begin
                  // a done landing with a write still clears its own bit
                  recal_request <= (recal_request & ~recal_done) | reg_wdata[5:0];
                  recal_start <= reg_wdata[5:0];
               end
               `TEQ_ADDR_IRQ_EN: irq_enable <= reg_wdata[5:0];
               `TEQ_ADDR_RPT_EN: autorepeat_enable <= reg_wdata[5:0];
               `TEQ_ADDR_MT_CFG: begin
                  touch_blocking_enable <= reg_wdata[`TEQ_MT_BLK_BIT];
                  simultaneous_touch_limit <= reg_wdata[`TEQ_MT_LIM_HI:`TEQ_MT_LIM_LO];
               end
               `TEQ_ADDR_PAT_CFG: begin
                  pattern_cfg <= reg_wdata & 8'h8f;
                  pattern_threshold_fraction <= reg_wdata[`TEQ_PAT_TH_HI:`TEQ_PAT_TH_LO];
               end
               `TEQ_ADDR_PAT_SEL: pattern_select <= reg_wdata[5:0];
               `TEQ_ADDR_TIMING: min_press <= reg_wdata[3:0];
               `TEQ_ADDR_RPT_CFG: repeat_interval <= reg_wdata[3:0];
               default: begin
               end
            endcase
         end
         if (!(reg_wr && reg_addr == `TEQ_ADDR_RECAL))
            recal_request <= recal_request & ~recal_done;
         touch_status <= qual_touch;
         case (pat_state)
            ST_IDLE: if (pat_rise) pat_state <= ST_BLOCK;
            ST_BLOCK: if (!pat_cond) pat_state <= ST_IDLE;
            default: pat_state <= ST_IDLE;
         endcase
         // set wins over a clear in the same cycle
         if (pat_rise)
            pattern_event_flag <= 1'b1;
         else if (st_clear && !pat_cond)
            pattern_event_flag <= 1'b0;
         if (pat_rise && pattern_alert_enable)
            alert_flag <= 1'b1;
         else if (st_clear)
            alert_flag <= 1'b0;
         if (excess)
            too_many_touches_flag <= 1'b1;
         else if (st_clear)
            too_many_touches_flag <= 1'b0;
         if (touch_irq || pat_rise)
            irq_flag <= 1'b1;
         else if (st_clear)
            irq_flag <= 1'b0;
         irq_n <= !(touch_irq || pat_rise || (irq_flag && !st_clear));
         alert_n <= !((pat_rise && pattern_alert_enable) || (alert_flag && !st_clear));
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `TEQ_ADDR_STATUS: reg_rdata <= {5'h0, too_many_touches_flag, pattern_event_flag, irq_flag};
               `TEQ_ADDR_TOUCH: reg_rdata <= {2'b00, touch_status};
               `TEQ_ADDR_RECAL: reg_rdata <= {2'b00, recal_request};
               `TEQ_ADDR_IRQ_EN: reg_rdata <= {2'b00, irq_enable};
               `TEQ_ADDR_RPT_EN: reg_rdata <= {2'b00, autorepeat_enable};
               `TEQ_ADDR_MT_CFG: reg_rdata <= {touch_blocking_enable, 3'h0, simultaneous_touch_limit, 2'h0};
               `TEQ_ADDR_PAT_CFG: reg_rdata <= pattern_cfg;
               `TEQ_ADDR_PAT_SEL: reg_rdata <= {2'b00, pattern_select};
               `TEQ_ADDR_TIMING: reg_rdata <= {4'h0, min_press};
               `TEQ_ADDR_RPT_CFG: reg_rdata <= {4'h0, repeat_interval};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [tb/teq_fe_model.sv]
/*
 front end model: answers each recalibration start with a done pulse.
 assumes recal_start is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module teq_fe_model #(
   parameter int DLY = 20
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // recalibration
   input wire logic [5:0] recal_start,
   output logic [5:0] recal_done
);
   logic [5:0] busy;
   int cnt;
   always @(posedge clk_sys) begin
      recal_done <= 6'h00;
      if (!nrst) begin
         busy <= 6'h00;
         cnt <= 0;
      end else if (recal_start != 6'h00) begin
         busy <= busy | recal_start;
         cnt <= DLY;
      end else if (busy != 6'h00 && cnt == 1) begin
         recal_done <= busy;
         busy <= 6'h00;
         cnt <= 0;
      end else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule
`default_nettype wire

// [tb/teq_props.sv]
/*
 assertions on the qualifier ports, bound into teq_top.
 assumes the register offsets of teq_defs.vh.
*/
`timescale 1ns/100ps
`default_nettype none
`include "teq_defs.vh"
module teq_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // outputs
   input wire logic [5:0] recal_start,
   input wire logic [1:0] pattern_threshold_fraction,
   input wire logic irq_n,
   input wire logic alert_n
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   logic alert_en;
   wire clr = reg_wr && reg_addr == `TEQ_ADDR_STATUS && !reg_wdata[0];
   wire recal_wr = reg_wr && reg_addr == `TEQ_ADDR_RECAL;
   always @(posedge clk_sys)
      if (!nrst)
         alert_en <= 1'b0;
      else if (reg_wr && reg_addr == `TEQ_ADDR_PAT_CFG)
         alert_en <= reg_wdata[7] & reg_wdata[0];
   a_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero");
   a_recal_copy: assert property (
      recal_wr |=> recal_start == $past(reg_wdata[5:0])) else $error("recal start wrong");
   a_recal_pulse: assert property (
      !recal_wr |=> recal_start == 6'h00) else $error("recal start not a pulse");
   a_frac_copy: assert property (
      reg_wr && reg_addr == `TEQ_ADDR_PAT_CFG |=> pattern_threshold_fraction == $past(reg_wdata[3:2]))
      else $error("fraction wrong");
   a_irq_hold: assert property (
      !irq_n && !clr |=> !irq_n) else $error("irq released early");
   a_alert_hold: assert property (
      !alert_n && !clr |=> !alert_n) else $error("alert released early");
   a_alert_irq: assert property (
      !alert_n |-> !irq_n) else $error("alert without irq");
   a_alert_gated: assert property (
      $fell(alert_n) |-> alert_en) else $error("alert while disabled");
   c_irq: cover property ($fell(irq_n));
   c_alert: cover property ($fell(alert_n));
   c_recal: cover property (recal_start != 6'h00);
endmodule
bind teq_top teq_props props_u(.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .recal_start(recal_start),
   .pattern_threshold_fraction(pattern_threshold_fraction), .irq_n(irq_n), .alert_n(alert_n));
`default_nettype wire

// [tb/teq_tb_top.sv]
/*
 bench for teq_top: reads are checked from a queue, pins directly.
 assumes teq_fe_model answers recalibration.
*/
`timescale 1ns/100ps
`default_nettype none
module teq_tb_top;
   logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rel_sel = 0, rd_seen = 0, irq_n, alert_n;
   logic [7:0] reg_addr = 0, reg_wdata = 0, rdata;
   logic [5:0] touch = 0, over = 0, noise = 0, rstart, rdone;
   logic [1:0] frac;
   logic [7:0] exp_q[$], msk_q[$];
   logic [7:0] ra[9] = '{8'h27, 8'h28, 8'h2a, 8'h2b, 8'h2d, 8'h26, 8'h23, 8'h22, 8'h7f};
   logic [7:0] rv[9] = '{8'h3f, 8'h3f, 8'h80, 8'h00, 8'h3f, 8'h00, 8'h07, 8'h04, 8'h00};
   logic [31:0] seed = 32'h5875;
   int bad_count = 0, total_checks = 0, cyc = 0;
   teq_top #(.STEP_CYC(10)) dut_u(.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .raw_touch(touch),
      .over_pattern_th(over), .noise_flag(noise), .recal_done(rdone), .release_irq_select(rel_sel),
      .recal_start(rstart), .pattern_threshold_fraction(frac), .irq_n(irq_n), .alert_n(alert_n));
   teq_fe_model #(.DLY(20)) fe_u(.clk_sys(clk_sys), .nrst(nrst), .recal_start(rstart), .recal_done(rdone));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input [7:0] seen, input [7:0] want, input string what);
      total_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input [7:0] a, input [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 0;
   endtask
   task automatic rd(input [7:0] a, input [7:0] e, input [7:0] m);
      @(posedge clk_sys);
      reg_rd <= 1;
      reg_addr <= a;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clk_sys);
      reg_rd <= 0;
   endtask
   task automatic settle(input [5:0] t);
      touch <= t;
      repeat (5) @(posedge clk_sys);
   endtask
   task automatic poke(input [5:0] t, input int n, input logic want);
      touch <= t;
      repeat (n) @(posedge clk_sys);
      check({7'h0, irq_n}, {7'h0, want}, "irq_n");
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      rd_seen <= reg_rd;
      if (rd_seen)
         check(rdata & msk_q.pop_front(), exp_q.pop_front(), "reg_rdata");
      if (cyc == 5000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      nrst <= 1;
      for (int i = 0; i < 9; i++) rd(ra[i], rv[i], 8'hff);
      wr(8'h27, 8'hff);
      rd(8'h27, 8'h3f, 8'hff);
      wr(8'h23, 8'h03);
      rd(8'h23, 8'h03, 8'hff);
      wr(8'h23, 8'h07);
      seed = lfsr_next(seed);
      wr(8'h26, seed[7:0]);
      rd(8'h26, {2'b0, seed[5:0]}, 8'hff);
      repeat (30) @(posedge clk_sys);
      rd(8'h26, 8'h00, 8'hff);
      wr(8'h27, 8'h3e);
      poke(6'h01, 5, 1);
      poke(6'h00, 5, 1);
      wr(8'h27, 8'h3f);
      poke(6'h02, 5, 0);
      rd(8'h03, 8'h02, 8'hff);
      wr(8'h00, 8'h00);
      poke(6'h00, 5, 1);
      rel_sel <= 1;
      poke(6'h02, 5, 0);
      wr(8'h00, 8'h00);
      poke(6'h00, 5, 0);
      wr(8'h28, 8'h00);
      rel_sel <= 0;
      wr(8'h00, 8'h00);
      poke(6'h02, 5, 0);
      wr(8'h00, 8'h00);
      poke(6'h00, 5, 0);
      wr(8'h28, 8'h3f);
      wr(8'h22, 8'h00);
      wr(8'h00, 8'h00);
      poke(6'h02, 30, 0);
      wr(8'h00, 8'h00);
      poke(6'h02, 30, 1);
      for (int i = 0; i < 2; i++) begin
         wr(8'h00, 8'h00);
         poke(6'h02, 80, 0);
      end
      wr(8'h00, 8'h00);
      poke(6'h00, 5, 1);
      settle(6'h06);
      rd(8'h03, 8'h02, 8'hff);
      rd(8'h00, 8'h04, 8'h04);
      settle(6'h04);
      rd(8'h03, 8'h04, 8'hff);
      for (int c = 0; c < 4; c++) begin
         wr(8'h2a, {4'h8, c[1:0], 2'b0});
         settle(6'h00);
         settle(6'h3f);
         rd(8'h03, 8'((1 << (c + 1)) - 1), 8'hff);
      end
      wr(8'h2a, 8'h00);
      settle(6'h3f);
      rd(8'h03, 8'h3f, 8'hff);
      over <= 6'h3f;
      settle(6'h00);
      rd(8'h00, 8'h00, 8'h02);
      wr(8'h2d, 8'h03);
      wr(8'h2b, 8'h81);
      over <= 6'h30;
      settle(6'h01);
      check({7'h0, alert_n}, 8'h00, "alert_n");
      rd(8'h03, 8'h00, 8'hff);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h02, 8'h02);
      over <= 6'h00;
      settle(6'h01);
      rd(8'h03, 8'h01, 8'hff);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h00, 8'h02);
      check({7'h0, alert_n}, 8'h01, "alert_n");
      wr(8'h2b, 8'h82);
      over <= 6'h30;
      settle(6'h00);
      rd(8'h00, 8'h00, 8'h02);
      over <= 6'h02;
      noise <= 6'h01;
      settle(6'h00);
      rd(8'h00, 8'h02, 8'h02);
      check({7'h0, alert_n}, 8'h01, "alert_n");
      for (int c = 0; c < 4; c++) begin
         wr(8'h2b, {4'h0, c[1:0], 2'b0});
         @(posedge clk_sys);
         check({6'h0, frac}, {6'h0, c[1:0]}, "fraction");
      end
      complete_run();
   end
endmodule
`default_nettype wire
